// ### hdl/wlt_consts.svh
// constants for the waveform logging trigger block
`ifndef WLT_CONSTS_SVH
`define WLT_CONSTS_SVH
// clock rate, communication cycle choices and number of trigger settings
`define WLT_CLK_MHZ        200
`define WLT_CYC0_US        500
`define WLT_CYC1_US        1000
`define WLT_CYC2_US        2000
`define WLT_CYC3_US        4000
`define WLT_NUM_TRIG       16
// register byte offsets
`define WLT_OFF_CTRL       12'h000
`define WLT_OFF_STATUS     12'h004
`define WLT_OFF_CFG_SEL    12'h008
`define WLT_OFF_CFG_WORD   12'h00C
`define WLT_OFF_WINDOW     12'h010
// control fields
`define WLT_CTRL_EN_BIT    0
`define WLT_CTRL_CYC_LSB   1
`define WLT_CTRL_RUN_LSB   4
`define WLT_CTRL_RST       32'h00000000
// status fields
`define WLT_ST_ACTIVE_BIT  0
`define WLT_ST_PRESENT_BIT 1
`define WLT_ST_EN_BIT      2
`define WLT_ST_STATE_LSB   4
`define WLT_ST_INDEX_LSB   8
// per-trigger configuration word fields
`define WLT_F_MULT_LSB     0
`define WLT_F_COUNT_LSB    8
`define WLT_F_MODE_LSB     19
`define WLT_F_POS_LSB      21
`define WLT_F_COMB_LSB     24
`define WLT_F_EDGEA_LSB    26
`define WLT_F_EDGEB_LSB    28
`define WLT_CFG_RST        32'h00000801
// accepted ranges
`define WLT_MULT_MIN       1
`define WLT_MULT_MAX       255
`define WLT_COUNT_MIN      8
`define WLT_COUNT_MAX      1024
`endif

// ### hdl/wlt_pkg.sv
// types shared by the waveform logging trigger modules
`default_nettype none
package wlt_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_AUTO   = 2'h2
  } mode_t;
  typedef enum logic [1:0] {
    COMB_A   = 2'h0,
    COMB_B   = 2'h1,
    COMB_AND = 2'h2,
    COMB_OR  = 2'h3
  } comb_t;
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE  = 4'h2,
    ST_POST = 4'h4,
    ST_DONE = 4'h8
  } state_t;
endpackage
`default_nettype wire

// ### hdl/cfg_port_if.sv
// write port and two read ports of the trigger settings memory
`default_nettype none
interface cfg_port_if #(parameter int AW = 4, parameter int DW = 32);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr_a;
  logic [DW-1:0] rdata_a;
  logic [AW-1:0] raddr_b;
  logic [DW-1:0] rdata_b;
  modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface
`default_nettype wire

// ### hdl/cfg_mem.sv
// per-trigger settings store with registered read ports
`default_nettype none
`include "wlt_consts.svh"
module cfg_mem #(
  parameter int DEPTH = `WLT_NUM_TRIG,
  parameter int AW    = 4,
  parameter int DW    = 32
) (
  input  wire logic   mclk,
  input  wire logic   sys_rst,
  cfg_port_if.mem     port
);
  logic [DW-1:0] store [DEPTH];

  // reset gives every trigger a legal default setting
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= DW'(`WLT_CFG_RST);
      end
    end else if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  // read data comes out of registers, one cycle behind the address
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port.rdata_a <= '0;
      port.rdata_b <= '0;
    end else begin
      port.rdata_a <= store[port.raddr_a];
      port.rdata_b <= store[port.raddr_b];
    end
  end
endmodule
`default_nettype wire

// ### hdl/comm_tick_gen.sv
// communication cycle tick divider
`default_nettype none
module comm_tick_gen #(
  parameter int CNT0 = 100000,
  parameter int CNT1 = 200000,
  parameter int CNT2 = 400000,
  parameter int CNT3 = 800000
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [1:0] cyc_sel,
  output logic            tick
);
  logic [19:0] cnt;
  logic [19:0] limit;

  // period in clocks for the selected cycle
  always_comb begin
    unique case (cyc_sel)
      2'h0: limit = 20'(CNT0 - 1);
      2'h1: limit = 20'(CNT1 - 1);
      2'h2: limit = 20'(CNT2 - 1);
      2'h3: limit = 20'(CNT3 - 1);
    endcase
  end

  // restarts with run so the first tick is one full cycle after start
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == limit);
      cnt  <= (cnt == limit) ? '0 : cnt + 20'h00001;
    end
  end
endmodule
`default_nettype wire

// ### hdl/waveform_logging_trigger.sv
// waveform logging trigger and sampling control with apb registers
// Operation
// - sampling period is the communication cycle times the trigger's multiplier
// - multiplier is accepted only from 1 to 255
// - communication cycle is selectable as 500, 1000, 2000 or 4000 us
// - samples per run equal measurement time over sampling period
// - sample count is accepted only from 8 to 1024
// - window is cycle times multiplier times sample count
// - window spans 4 ms to 130.560 s at 0.5 ms, up to 1044.480 s
// - single mode captures one run on the first trigger, then stays done
// - normal mode captures a run on every trigger taken in the pre-trigger state, then re-arms
// - combination A fires when condition A is met
// - combination B fires when condition B is met
// - combination A and B fires only when both are met together
// - combination A or B fires when either condition is met
// - auto mode raises the active flag at once on start
// - each condition is a rising, falling or either edge of a bit
// - sixteen trigger numbers each keep their own settings
// - dropping the logging enable aborts a run in progress
`default_nettype none
`include "wlt_consts.svh"
module waveform_logging_trigger #(
  parameter int CYC0_CLKS = `WLT_CYC0_US * `WLT_CLK_MHZ,
  parameter int CYC1_CLKS = `WLT_CYC1_US * `WLT_CLK_MHZ,
  parameter int CYC2_CLKS = `WLT_CYC2_US * `WLT_CLK_MHZ,
  parameter int CYC3_CLKS = `WLT_CYC3_US * `WLT_CLK_MHZ
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] cond_a_bits,
  input  wire logic [15:0] cond_b_bits,
  output logic             sample_strobe,
  output logic      [10:0] sample_index,
  output logic      [3:0]  sample_trig_no,
  output logic             trigger_hit,
  output logic             logging_active,
  output logic             data_present
);
  import wlt_pkg::*;

  // settings word decode
  function automatic logic [7:0] f_mult(input logic [31:0] w);
    return w[`WLT_F_MULT_LSB +: 8];
  endfunction
  function automatic logic [10:0] f_count(input logic [31:0] w);
    return w[`WLT_F_COUNT_LSB +: 11];
  endfunction

  // range check applied to every settings write
  function automatic logic cfg_ok(input logic [31:0] w);
    return (f_mult(w) >= 8'(`WLT_MULT_MIN)) && (f_mult(w) <= 8'(`WLT_MULT_MAX))
        && (f_count(w) >= 11'(`WLT_COUNT_MIN)) && (f_count(w) <= 11'(`WLT_COUNT_MAX))
        && (w[`WLT_F_MODE_LSB +: 2] != 2'h3);
  endfunction

  function automatic logic [12:0] cycle_us(input logic [1:0] s);
    logic [12:0] r;
    r = 13'h0000;
    unique case (s)
      2'h0: r = 13'(`WLT_CYC0_US);
      2'h1: r = 13'(`WLT_CYC1_US);
      2'h2: r = 13'(`WLT_CYC2_US);
      2'h3: r = 13'(`WLT_CYC3_US);
    endcase
    return r;
  endfunction

  // window in microseconds; 4000*255*1024 still fits 32 bits
  function automatic logic [31:0] window_us(input logic [1:0] s, input logic [31:0] w);
    return 32'(cycle_us(s)) * 32'(f_mult(w)) * 32'(f_count(w));
  endfunction

  function automatic logic edge_hit(input edge_t m, input logic p, input logic c);
    logic r;
    r = 1'b0;
    unique case (m)
      EDGE_OFF:  r = 1'b0;
      EDGE_RISE: r = !p && c;
      EDGE_FALL: r = p && !c;
      EDGE_BOTH: r = p != c;
    endcase
    return r;
  endfunction

  logic [31:0] ctrl;
  logic [3:0]  cfg_sel;
  logic        rd_wait;
  logic        en_d;
  logic        en_d2;
  logic        start;
  logic        enable;
  logic [1:0]  cyc_sel;
  logic [3:0]  run_sel;
  logic        comm_tick;
  logic        running;
  logic        sample_tick;
  logic [7:0]  mult_cnt;
  logic [31:0] cur_cfg;
  logic [10:0] pre_need;
  logic [10:0] pre_cnt;
  logic [10:0] post_left;
  logic [10:0] idx;
  logic        prev_a;
  logic        prev_b;
  logic        ev_a;
  logic        ev_b;
  logic        hit_a;
  logic        hit_b;
  logic        fire;
  logic        accept;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        wr_bad;
  logic [31:0] rd_mux;
  state_t      state;
  mode_t       cur_mode;
  comb_t       cur_comb;

  cfg_port_if #(.AW(4), .DW(32)) cfg_bus ();

  cfg_mem #(.DEPTH(`WLT_NUM_TRIG), .AW(4), .DW(32)) u_mem (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .port    (cfg_bus.mem)
  );

  comm_tick_gen #(
    .CNT0 (CYC0_CLKS),
    .CNT1 (CYC1_CLKS),
    .CNT2 (CYC2_CLKS),
    .CNT3 (CYC3_CLKS)
  ) u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (running),
    .cyc_sel (cyc_sel),
    .tick    (comm_tick)
  );

  // control fields
  assign enable  = ctrl[`WLT_CTRL_EN_BIT];
  assign cyc_sel = ctrl[`WLT_CTRL_CYC_LSB +: 2];
  assign run_sel = ctrl[`WLT_CTRL_RUN_LSB +: 4];

  // apb decode; writes take no wait, reads take one for the memory port
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign addr_ok = (paddr == `WLT_OFF_CTRL) || (paddr == `WLT_OFF_STATUS)
                || (paddr == `WLT_OFF_CFG_SEL) || (paddr == `WLT_OFF_CFG_WORD)
                || (paddr == `WLT_OFF_WINDOW);
  assign wr_bad  = pwrite && ((paddr == `WLT_OFF_STATUS) || (paddr == `WLT_OFF_WINDOW)
                || ((paddr == `WLT_OFF_CFG_WORD) && !cfg_ok(pwdata)));
  assign pready  = pwrite ? 1'b1 : rd_wait;
  assign pslverr = psel && penable && pready && (!addr_ok || wr_bad);

  assign cfg_bus.we      = wr_acc && (paddr == `WLT_OFF_CFG_WORD) && cfg_ok(pwdata);
  assign cfg_bus.waddr   = cfg_sel;
  assign cfg_bus.wdata   = pwdata;
  assign cfg_bus.raddr_a = cfg_sel;
  assign cfg_bus.raddr_b = run_sel;

  // control and selection registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl    <= `WLT_CTRL_RST;
      cfg_sel <= 4'h0;
    end else if (wr_acc && (paddr == `WLT_OFF_CTRL)) begin
      ctrl    <= {24'h000000, pwdata[7:0]};
    end else if (wr_acc && (paddr == `WLT_OFF_CFG_SEL)) begin
      cfg_sel <= pwdata[3:0];
    end
  end

  // read mux; unused bits read zero except ctrl bit 3 and settings word bits 30-31
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      `WLT_OFF_CTRL:     rd_mux = ctrl;
      `WLT_OFF_CFG_SEL:  rd_mux = {28'h0000000, cfg_sel};
      `WLT_OFF_CFG_WORD: rd_mux = cfg_bus.rdata_a;
      // window readback of the edited trigger
      `WLT_OFF_WINDOW:   rd_mux = window_us(cyc_sel, cfg_bus.rdata_a);
      `WLT_OFF_STATUS: begin
        rd_mux[`WLT_ST_ACTIVE_BIT]     = logging_active;
        rd_mux[`WLT_ST_PRESENT_BIT]    = data_present;
        rd_mux[`WLT_ST_EN_BIT]         = enable;
        rd_mux[`WLT_ST_STATE_LSB +: 4] = state;
        rd_mux[`WLT_ST_INDEX_LSB +: 11] = idx;
      end
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // read wait state and registered read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_wait <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      rd_wait <= rd_acc && !rd_wait;
      if (rd_acc && !rd_wait) begin
        prdata <= addr_ok ? rd_mux : 32'h00000000;
      end
    end
  end

  // start is delayed one cycle so the run trigger's settings are read back
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_d  <= 1'b0;
      en_d2 <= 1'b0;
    end else begin
      en_d  <= enable;
      en_d2 <= en_d;
    end
  end
  assign start = en_d && !en_d2 && enable;

  // latched settings for the current run
  assign cur_mode = mode_t'(cur_cfg[`WLT_F_MODE_LSB +: 2]);
  assign cur_comb = comb_t'(cur_cfg[`WLT_F_COMB_LSB +: 2]);
  // sampling period counter in communication ticks
  assign running     = (state == ST_PRE) || (state == ST_POST);
  assign sample_tick = comm_tick && (mult_cnt == (f_mult(cur_cfg) - 8'h01));
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mult_cnt <= 8'h00;
    end else if (!running) begin
      mult_cnt <= 8'h00;
    end else if (comm_tick) begin
      mult_cnt <= sample_tick ? 8'h00 : mult_cnt + 8'h01;
    end
  end

  // edge detection on the monitored bits
  assign ev_a = edge_hit(edge_t'(cur_cfg[`WLT_F_EDGEA_LSB +: 2]), prev_a, cond_a_bits[run_sel]);
  assign ev_b = edge_hit(edge_t'(cur_cfg[`WLT_F_EDGEB_LSB +: 2]), prev_b, cond_b_bits[run_sel]);

  // edges held until the next sample boundary; a new edge wins over the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      hit_a  <= 1'b0;
      hit_b  <= 1'b0;
    end else begin
      prev_a <= cond_a_bits[run_sel];
      prev_b <= cond_b_bits[run_sel];
      if (!running || sample_tick) begin
        hit_a <= ev_a && running;
        hit_b <= ev_b && running;
      end else begin
        hit_a <= hit_a || ev_a;
        hit_b <= hit_b || ev_b;
      end
    end
  end

  // combination of the two conditions within one sampling period
  always_comb begin
    fire = 1'b0;
    unique case (cur_comb)
      COMB_A:   fire = hit_a;
      COMB_B:   fire = hit_b;
      COMB_AND: fire = hit_a && hit_b;
      COMB_OR:  fire = hit_a || hit_b;
    endcase
  end
  // trigger is only taken once the pre-trigger slots are full
  assign accept = (state == ST_PRE) && sample_tick && fire && (pre_cnt == pre_need);

  // capture sequencer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      cur_cfg        <= `WLT_CFG_RST;
      pre_need       <= 11'h000;
      pre_cnt        <= 11'h000;
      post_left      <= 11'h000;
      idx            <= 11'h000;
      logging_active <= 1'b0;
      data_present   <= 1'b0;
    end else if (!enable) begin
      state          <= ST_IDLE;
      logging_active <= 1'b0;
    end else if (start) begin
      cur_cfg      <= cfg_bus.rdata_b;
      data_present <= 1'b0;
      idx          <= 11'h000;
      pre_cnt      <= 11'h000;
      pre_need     <= 11'(({14'(f_count(cfg_bus.rdata_b))
                      * 14'(cfg_bus.rdata_b[`WLT_F_POS_LSB +: 3])}) >> 3);
      if (mode_t'(cfg_bus.rdata_b[`WLT_F_MODE_LSB +: 2]) == MODE_AUTO) begin
        // active at once, window runs from start
        state          <= ST_POST;
        logging_active <= 1'b1;
        post_left      <= f_count(cfg_bus.rdata_b);
      end else begin
        state <= ST_PRE;
      end
    end else begin
      unique case (state)
        ST_IDLE, ST_DONE: begin
          state <= state;
        end
        ST_PRE: begin
          if (accept) begin
            // trigger sample opens the post-trigger part
            logging_active <= 1'b1;
            idx            <= pre_need + 11'h001;
            post_left      <= f_count(cur_cfg) - pre_need - 11'h001;
            if (f_count(cur_cfg) - pre_need == 11'h001) begin
              logging_active <= 1'b0;
              data_present   <= 1'b1;
              state          <= (cur_mode == MODE_NORMAL) ? ST_PRE : ST_DONE;
              idx            <= 11'h000;
              pre_cnt        <= 11'h000;
            end else begin
              state <= ST_POST;
            end
          end else if (sample_tick && (pre_need != 11'h000)) begin
            // pre-trigger ring, slot wraps at the pre length
            pre_cnt <= (pre_cnt == pre_need) ? pre_cnt : pre_cnt + 11'h001;
            idx     <= (idx == pre_need - 11'h001) ? 11'h000 : idx + 11'h001;
          end
        end
        ST_POST: begin
          if (sample_tick) begin
            // run ends after the configured sample count
            if (post_left == 11'h001) begin
              logging_active <= 1'b0;
              data_present   <= 1'b1;
              // single and auto stop, normal re-arms
              state          <= (cur_mode == MODE_NORMAL) ? ST_PRE : ST_DONE;
              idx            <= 11'h000;
              pre_cnt        <= 11'h000;
            end else begin
              post_left <= post_left - 11'h001;
              idx       <= idx + 11'h001;
            end
          end
        end
      endcase
    end
  end

  // sample strobe toward the storage, registered with its slot and trigger number
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_strobe  <= 1'b0;
      sample_index   <= 11'h000;
      sample_trig_no <= 4'h0;
      trigger_hit    <= 1'b0;
    end else begin
      // one strobe per sampling boundary while capturing
      sample_strobe  <= enable && !start && sample_tick
                     && ((state == ST_POST) || accept || (pre_need != 11'h000));
      // the trigger sample always lands in the slot just after the pre ring
      sample_index   <= accept ? pre_need : idx;
      sample_trig_no <= run_sel;
      trigger_hit    <= enable && !start && accept;
    end
  end
endmodule
`default_nettype wire

// ### tb/wlt_monitor.sv
// port checks for the waveform logging trigger block
`default_nettype none
module wlt_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_strobe,
  input wire logic [10:0] sample_index,
  input wire logic        trigger_hit,
  input wire logic        logging_active
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // write access phase, and one aimed at the settings word
  logic wr;
  logic wcfg;
  assign wr   = psel && penable && pwrite;
  assign wcfg = wr && paddr == 12'h00C;
  AST_WRITE_READY: assert property (wr |-> pready)
    else $error("write not answered at once");
  AST_READ_WAIT: assert property ($rose(penable) && psel && !pwrite |-> !pready ##1 pready)
    else $error("read wait state wrong");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_MULT_REFUSED: assert property (wcfg && pwdata[7:0] == 8'h00 |-> pslverr)
    else $error("zero multiplier accepted");
  AST_COUNT_REFUSED: assert property (wcfg && (pwdata[18:8] < 11'h008
      || pwdata[18:8] > 11'h400) |-> pslverr)
    else $error("sample count out of range accepted");
  AST_INDEX_RANGE: assert property (sample_strobe |-> sample_index < 11'h400)
    else $error("slot index beyond largest count");
  // no second sample within eight clocks of a sample
  AST_STROBE_GAP: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("samples too close together");
  AST_ABORT: assert property (wr && paddr == 12'h000 && !pwdata[0]
      |-> ##2 (!logging_active && !sample_strobe) [*4])
    else $error("run not stopped by enable drop");
  AST_HIT_SAMPLE: assert property (trigger_hit |-> ##[0:2] sample_strobe)
    else $error("accepted trigger took no sample");
endmodule
bind waveform_logging_trigger wlt_monitor mon (.mclk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .sample_strobe, .sample_index, .trigger_hit,
  .logging_active);
`default_nettype wire

// ### tb/host_apb.sv
// host program model: apb master driving the register port
`default_nettype none
module host_apb (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hang = 1'h0;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // one transfer; request held until pready seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // pready, data and error are taken at the rising edge the slave answers on
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    hang = (n >= 64);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ### tb/waveform_logging_trigger_test.sv
// self-checking bench for the waveform logging trigger block
`default_nettype none
module waveform_logging_trigger_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wlt_pkg::*;
  localparam int TICK = 10;
  logic        mclk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] cond_a_bits = '0;
  logic [15:0] cond_b_bits = '0;
  logic        sample_strobe, trigger_hit, logging_active, data_present;
  logic [10:0] sample_index;
  logic [3:0]  sample_trig_no;
  int          fails = 0;
  int          compares = 0;
  int          hits = 0;
  int          us[4] = '{500, 1000, 2000, 4000};
  int          bad[4][3] = '{'{0, 8, 0}, '{1, 7, 0}, '{1, 1025, 0}, '{1, 8, 3}};
  // comb, edge a, edge b, start a, start b, end a, end b, hit expected
  int          tbl[7][8] = '{'{COMB_A, EDGE_RISE, EDGE_OFF, 0, 0, 1, 0, 1},
    '{COMB_B, EDGE_OFF, EDGE_FALL, 0, 1, 0, 0, 1}, '{COMB_A, EDGE_BOTH, EDGE_OFF, 1, 0, 0, 0, 1},
    '{COMB_A, EDGE_RISE, EDGE_OFF, 1, 0, 0, 0, 0}, '{COMB_AND, EDGE_RISE, EDGE_RISE, 0, 0, 1, 0, 0},
    '{COMB_AND, EDGE_RISE, EDGE_RISE, 0, 0, 1, 1, 1},
    '{COMB_OR, EDGE_RISE, EDGE_RISE, 0, 0, 0, 1, 1}};
  always #2.5 mclk = ~mclk;
  // short communication cycles keep the run brief
  waveform_logging_trigger #(.CYC0_CLKS(TICK), .CYC1_CLKS(20), .CYC2_CLKS(40),
    .CYC3_CLKS(80)) DUT (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cond_a_bits, .cond_b_bits, .sample_strobe, .sample_index,
    .sample_trig_no, .trigger_hit, .logging_active, .data_present);
  host_apb host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // count accepted triggers where the pulse has settled
  always @(negedge mclk) begin
    if (trigger_hit === 1'h1) hits++;
  end
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic quit;
    fails++;
    complete_run();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // register access; reads compare data, all compare the error flag
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    logic [31:0] q;
    logic        e;
    host.xfer(w, a, d, q, e);
    if (host.hang) quit();
    check({31'h0, e}, {31'h0, er});
    if (!w) check(q, d);
  endtask
  // host keeps multiplier, count and mode legal unless refusal is wanted
  // host settings
  function automatic logic [31:0] cw(input int m, c, md, pos, cb, ea, eb);
    return {2'h0, eb[1:0], ea[1:0], cb[1:0], pos[2:0], md[1:0], c[10:0], m[7:0]};
  endfunction
  // stop, set levels, load trigger tn, start on the shortest cycle
  task automatic arm(input logic [3:0] tn, input logic [31:0] w, input logic la, lb);
    acc(1'h1, 12'h000, 32'h0, 1'h0);
    cond_a_bits <= {16{la}};
    cond_b_bits <= {16{lb}};
    acc(1'h1, 12'h008, {28'h0, tn}, 1'h0);
    acc(1'h1, 12'h00C, w, 1'h0);
    acc(1'h1, 12'h000, {24'h0, tn, 4'h1}, 1'h0);
  endtask
  task automatic next_strobe(output logic [10:0] idx, output int gap);
    gap = 0;
    do begin
      @(negedge mclk);
      gap++;
      if (gap > 3000) quit();
    end while (sample_strobe !== 1'h1);
    idx = sample_index;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    quit();
  end
  initial begin
    logic [10:0] idx;
    int          gap;
    int          h;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    acc(1'h0, 12'h004, 32'h00000010, 1'h0);
    acc(1'h0, 12'h00C, 32'h00000801, 1'h0);
    acc(1'h0, 12'h010, 32'h00000FA0, 1'h0);
    acc(1'h0, 12'h020, 32'h0, 1'h1);
    acc(1'h1, 12'h004, 32'h0, 1'h1);
    acc(1'h1, 12'h00C, cw(255, 1024, 0, 0, 0, 0, 0), 1'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, 12'h000, 32'(i * 2), 1'h0);
      acc(1'h0, 12'h010, 32'(us[i] * 255 * 1024), 1'h0);
      acc(1'h1, 12'h00C, cw(bad[i][0], bad[i][1], bad[i][2], 0, 0, 0, 0), 1'h1);
      acc(1'h0, 12'h00C, cw(255, 1024, 0, 0, 0, 0, 0), 1'h0);
    end
    acc(1'h1, 12'h008, 32'h00000006, 1'h0);
    acc(1'h0, 12'h00C, 32'h00000801, 1'h0);
    $display("test registers done");
    // single run on trigger 1, half the window before the trigger
    arm(4'h1, cw(2, 8, MODE_SINGLE, 4, COMB_A, EDGE_RISE, EDGE_OFF), 1'h0, 1'h0);
    h = hits;
    repeat (4) next_strobe(idx, gap);
    @(posedge mclk);
    cond_a_bits[1] <= 1'h1;
    next_strobe(idx, gap);
    check(32'(idx), 32'h4);
    check(32'(sample_trig_no), 32'h1);
    for (int k = 5; k < 8; k++) begin
      next_strobe(idx, gap);
      check(32'(idx), 32'(k));
      check(32'(gap), 32'h14);
    end
    repeat (4) @(negedge mclk);
    check({30'h0, logging_active, data_present}, 32'h1);
    @(posedge mclk);
    cond_a_bits[1] <= 1'h0;
    repeat (3 * TICK) @(posedge mclk);
    cond_a_bits[1] <= 1'h1;
    repeat (9 * TICK) @(negedge mclk);
    check(32'(hits - h), 32'h1);
    $display("test single done");
    // each combination of the two conditions, trigger 3
    for (int r = 0; r < 7; r++) begin
      arm(4'h3, cw(1, 8, MODE_SINGLE, 0, tbl[r][0], tbl[r][1], tbl[r][2]),
        tbl[r][3][0], tbl[r][4][0]);
      repeat (3 * TICK) @(posedge mclk);
      h = hits;
      cond_a_bits[3] <= tbl[r][5][0];
      cond_b_bits[3] <= tbl[r][6][0];
      repeat (4 * TICK) @(negedge mclk);
      check(32'(hits != h), 32'(tbl[r][7]));
    end
    $display("test conditions done");
    // normal mode re-arms after each run; third run is aborted
    arm(4'h0, cw(1, 8, MODE_NORMAL, 0, COMB_A, EDGE_RISE, EDGE_OFF), 1'h0, 1'h0);
    h = hits;
    for (int n = 0; n < 3; n++) begin
      repeat (3 * TICK) @(posedge mclk);
      cond_a_bits[0] <= 1'h1;
      repeat ((n < 2) ? 12 * TICK : 3 * TICK) @(posedge mclk);
      cond_a_bits[0] <= 1'h0;
    end
    @(negedge mclk);
    check(32'(hits - h), 32'h3);
    check({30'h0, logging_active, data_present}, 32'h3);
    acc(1'h1, 12'h000, 32'h0, 1'h0);
    repeat (2) @(negedge mclk);
    check({31'h0, logging_active}, 32'h0);
    $display("test normal done");
    // auto mode goes active at start with no trigger
    arm(4'h0, cw(1, 8, MODE_AUTO, 0, COMB_A, EDGE_OFF, EDGE_OFF), 1'h0, 1'h0);
    repeat (4) @(negedge mclk);
    check({31'h0, logging_active}, 32'h1);
    next_strobe(idx, gap);
    check(32'(idx), 32'h0);
    repeat (7) next_strobe(idx, gap);
    check(32'(idx), 32'h7);
    $display("test auto done");
    complete_run();
  end
endmodule
`default_nettype wire
